// *** verilog/cfg_loader_pkg.sv ***
/*
 Package for the power-up configuration loader: sizes, timing constants,
 loader states and the packed carriers shared by the loader and the limiter.
 Assumes a 40 MHz device clock.
*/
package cfg_loader_pkg;

   // Configuration image layout: two limit bytes per margining channel
   localparam int NUM_DAC = 6;
   localparam int CFG_WORDS = 2 * NUM_DAC;
   localparam int CFG_ADDR_W = 4;
   localparam int DAC_W = 8;

   // Word index of each limit inside the image
   localparam logic [CFG_ADDR_W-1:0] LOWER_BASE = 4'h0;
   localparam logic [CFG_ADDR_W-1:0] UPPER_BASE = 4'h6;

   // Reset values
   localparam logic [DAC_W-1:0] LIMIT_RESET = 8'h00;

   // Timing
   localparam longint CLK_HZ = 40000000;
   localparam longint SE_DELAY_NS = 500000;  // 0.5 ms
   localparam longint SE_DELAY_CYC = (SE_DELAY_NS * CLK_HZ) / 1000000000;
   localparam int DELAY_W = 16;

   // Loader sequence
   typedef enum logic [2:0] {
      LD_IDLE,
      LD_READ,
      LD_WAIT,
      LD_XFER,
      LD_DELAY,
      LD_SEFETCH,
      LD_RUN
   } loader_state_t;

   // One margining channel's limits
   typedef struct packed {
      logic [DAC_W-1:0] lower;
      logic [DAC_W-1:0] upper;
   } dac_limits_t;

   // Limiter result for one channel
   typedef struct packed {
      logic [DAC_W-1:0] code;
      logic bufferEnable;
   } dac_drive_t;

endpackage

// *** verilog/dac_limiter.sv ***
/*
 Clips one margining DAC code between its lower and upper limits and
 disables the output buffer when the limits are inverted.
 Assumes limits and code are stable register outputs on the same clock.
*/
`timescale 1ns/1ps
module dac_limiter (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [7:0] writtenCode,
   input wire cfg_loader_pkg::dac_limits_t limits,
   output cfg_loader_pkg::dac_drive_t drive
);

   cfg_loader_pkg::dac_drive_t drive_d;

   // Clip against limits; inverted limits three-state the buffer
   always_comb begin
      drive_d.bufferEnable = !(limits.lower > limits.upper);
      if (writtenCode < limits.lower) begin
         drive_d.code = limits.lower;
      end else if (writtenCode > limits.upper) begin
         drive_d.code = limits.upper;
      end else begin
         drive_d.code = writtenCode;
      end
   end

   // Registered result
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         drive <= '0;
      end else begin
         drive <= drive_d;
      end
   end

endmodule // dac_limiter

// *** verilog/config_download_dac_limiter.sv ***
/*
 Power-up configuration loader with margining DAC limiting.
 Copies the nonvolatile image into staging latches, then transfers all to
 the active latches in one pulse, waits, and fetches the first sequencer
 state. Serial access is refused until loading is done.
 Assumes a nonvolatile memory with a read request and one-shot data valid,
 and a supply monitor whose levels come from the analog domain.
*/
`timescale 1ns/1ps

// Notes on behaviour
// - Each setting has a staging latch and an active latch, staging written first.
// - Every power-up restores the latches from nonvolatile memory.
// - Driver outputs float unpowered, weakly pulled low once any supply is present.
// - Copying starts only after undervoltage lockout releases.
// - Fill all staging latches, then pulse all active copies at once.
// - Fixed 0.5 ms after load completes, fetch the first sequencer state.
// - Bus transactions before load completion get a not-acknowledge.
// - Applied DAC code is the written code clipped to the limits.
// - Lower limit above upper limit forces the DAC buffer off.
// - DAC limits are part of the downloaded configuration.
// - DAC codes and limits are eight-bit unsigned.
module config_download_dac_limiter (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic supplyPresent,
   input wire logic lockoutReleased,
   output logic nvReadReq,
   output logic [3:0] nvAddr,
   input wire logic nvReadValid,
   input wire logic [7:0] nvReadData,
   output logic seFetchReq,
   input wire logic seFetchDone,
   input wire logic busStart,
   output logic busAckAllow,
   output logic loadComplete,
   output logic driverWeakPull,
   output logic driverHighZ,
   input wire logic [47:0] dacCodeRegister,
   output logic [47:0] dacCode,
   output logic [5:0] dacBufferEnable
);

   localparam int N = cfg_loader_pkg::NUM_DAC;
   localparam int W = cfg_loader_pkg::CFG_WORDS;

   logic supplyMeta_q;
   logic supplySync_q;
   logic lockMeta_q;
   logic lockSync_q;
   cfg_loader_pkg::loader_state_t state_q;
   logic [3:0] index_q;
   logic [7:0] staging_q [W];
   logic [7:0] active_q [W];
   logic transferPulse_q;
   logic [cfg_loader_pkg::DELAY_W-1:0] delay_q;
   logic nakPending_q;
   cfg_loader_pkg::dac_drive_t drive [N];

   // Two-stage synchronisers for the analog supply levels
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         supplyMeta_q <= 1'b0;
         supplySync_q <= 1'b0;
         lockMeta_q <= 1'b0;
         lockSync_q <= 1'b0;
      end else begin
         supplyMeta_q <= supplyPresent;
         supplySync_q <= supplyMeta_q;
         lockMeta_q <= lockoutReleased;
         lockSync_q <= lockMeta_q;
      end
   end

   // Driver outputs float until a supply appears, then weak pull-down
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         driverHighZ <= 1'b1;
         driverWeakPull <= 1'b0;
      end else begin
         driverHighZ <= !supplySync_q;
         driverWeakPull <= supplySync_q;
      end
   end

   // Loader sequence
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= cfg_loader_pkg::LD_IDLE;
      end else begin
         unique case (state_q)
            cfg_loader_pkg::LD_IDLE: begin
               if (lockSync_q) begin
                  state_q <= cfg_loader_pkg::LD_READ;
               end
            end
            cfg_loader_pkg::LD_READ: begin
               state_q <= cfg_loader_pkg::LD_WAIT;
            end
            cfg_loader_pkg::LD_WAIT: begin
               if (nvReadValid) begin
                  if (index_q == 4'(W - 1)) begin
                     state_q <= cfg_loader_pkg::LD_XFER;
                  end else begin
                     state_q <= cfg_loader_pkg::LD_READ;
                  end
               end
            end
            cfg_loader_pkg::LD_XFER: begin
               state_q <= cfg_loader_pkg::LD_DELAY;
            end
            cfg_loader_pkg::LD_DELAY: begin
               if (delay_q == cfg_loader_pkg::DELAY_W'(cfg_loader_pkg::SE_DELAY_CYC - 1)) begin
                  state_q <= cfg_loader_pkg::LD_SEFETCH;
               end
            end
            cfg_loader_pkg::LD_SEFETCH: begin
               if (seFetchDone) begin
                  state_q <= cfg_loader_pkg::LD_RUN;
               end
            end
            cfg_loader_pkg::LD_RUN: begin
               state_q <= cfg_loader_pkg::LD_RUN;
            end
         endcase
      end
   end

   // Image word index
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         index_q <= 4'h0;
      end else if (state_q == cfg_loader_pkg::LD_WAIT && nvReadValid) begin
         index_q <= index_q + 4'h1;
      end
   end

   // Read request and address toward nonvolatile memory
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         nvReadReq <= 1'b0;
         nvAddr <= 4'h0;
      end else begin
         nvReadReq <= (state_q == cfg_loader_pkg::LD_READ);
         nvAddr <= index_q;
      end
   end

   // Staging and active latch pairs, one per image word
   generate
      for (genvar i = 0; i < W; i++) begin : g_latch
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               staging_q[i] <= cfg_loader_pkg::LIMIT_RESET;
            end else if (state_q == cfg_loader_pkg::LD_WAIT && nvReadValid
                         && index_q == 4'(i)) begin
               staging_q[i] <= nvReadData;
            end
         end
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               active_q[i] <= cfg_loader_pkg::LIMIT_RESET;
            end else if (transferPulse_q) begin
               active_q[i] <= staging_q[i];
            end
         end
      end
   endgenerate

   // Single staging-to-active pulse after the last staging write
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         transferPulse_q <= 1'b0;
      end else begin
         transferPulse_q <= (state_q == cfg_loader_pkg::LD_XFER);
      end
   end

   // Load-complete flag, set once the active copies are written
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         loadComplete <= 1'b0;
      end else if (transferPulse_q) begin
         loadComplete <= 1'b1;
      end
   end

   // Sequencer delay counter, started by the load-complete flag
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         delay_q <= '0;
      end else if (state_q == cfg_loader_pkg::LD_DELAY && loadComplete) begin
         delay_q <= delay_q + 1'b1;
      end
   end

   // First sequencer state fetch request, held until done
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         seFetchReq <= 1'b0;
      end else begin
         seFetchReq <= (state_q == cfg_loader_pkg::LD_SEFETCH) && !seFetchDone;
      end
   end

   // A transaction started before load completion is refused throughout
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         nakPending_q <= 1'b0;
      end else if (busStart) begin
         nakPending_q <= !loadComplete;
      end
   end

   // Acknowledge permission toward the serial interface
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         busAckAllow <= 1'b0;
      end else begin
         busAckAllow <= loadComplete && !(busStart ? 1'b0 : nakPending_q);
      end
   end

   // Per-channel limiter from the active limit copies
   generate
      for (genvar c = 0; c < N; c++) begin : g_dac
         cfg_loader_pkg::dac_limits_t lim;
         assign lim.lower = active_q[cfg_loader_pkg::LOWER_BASE + c];
         assign lim.upper = active_q[cfg_loader_pkg::UPPER_BASE + c];
         dac_limiter u_lim (
            .clk(clk),
            .rst_b(rst_b),
            .writtenCode(dacCodeRegister[c*8 +: 8]),
            .limits(lim),
            .drive(drive[c])
         );
         assign dacCode[c*8 +: 8] = drive[c].code;
         assign dacBufferEnable[c] = drive[c].bufferEnable;
      end
   endgenerate

endmodule // config_download_dac_limiter

// *** bench/config_loader_properties.sv ***
/*
 Port assertions for the configuration loader.
 Assumes binding onto the loader top module and a 40 MHz clock.
*/
`timescale 1ns/1ps
module config_loader_properties (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic supplyPresent,
   input wire logic lockoutReleased,
   input wire logic nvReadReq,
   input wire logic [3:0] nvAddr,
   input wire logic nvReadValid,
   input wire logic seFetchReq,
   input wire logic seFetchDone,
   input wire logic busStart,
   input wire logic busAckAllow,
   input wire logic loadComplete,
   input wire logic driverWeakPull
);
   localparam int SE_MIN = 19999;
   localparam int SE_MAX = 20008;
   logic [15:0] sinceLoad_q;
   // Cycles since load completion, saturating
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sinceLoad_q <= 16'h0000;
      end else if (loadComplete && sinceLoad_q != 16'hFFFF) begin
         sinceLoad_q <= sinceLoad_q + 16'h0001;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   property p_nackEarly; !loadComplete |-> !busAckAllow; endproperty
   a_nackEarly: assert property (p_nackEarly) else $error("ack before load");
   property p_loadSticky; loadComplete |=> loadComplete; endproperty
   a_loadSticky: assert property (p_loadSticky) else $error("load flag dropped");
   property p_lockGate; nvReadReq |-> $past(lockoutReleased, 2); endproperty
   a_lockGate: assert property (p_lockGate) else $error("read under lockout");
   property p_noEarly; nvReadReq |-> !loadComplete; endproperty
   a_noEarly: assert property (p_noEarly) else $error("read after transfer");
   property p_xferLast; nvReadValid && nvAddr == 4'hB |-> ##[1:4] loadComplete; endproperty
   a_xferLast: assert property (p_xferLast) else $error("no transfer after last word");
   property p_seDelay; $rose(seFetchReq) |-> sinceLoad_q >= SE_MIN && sinceLoad_q <= SE_MAX;
   endproperty
   a_seDelay: assert property (p_seDelay) else $error("fetch delay wrong");
   property p_seHold; seFetchReq && !seFetchDone |=> seFetchReq; endproperty
   a_seHold: assert property (p_seHold) else $error("fetch request dropped");
   property p_pull; $rose(driverWeakPull) |-> $past(supplyPresent, 2); endproperty
   a_pull: assert property (p_pull) else $error("pull without supply");
   // Main scenarios reached
   cover property ($rose(loadComplete));
   cover property ($rose(seFetchReq));
   cover property (busStart ##1 busAckAllow);
endmodule // config_loader_properties

// *** bench/nv_memory_model.sv ***
/*
 Nonvolatile memory model: serves image words and the first state fetch.
 Assumes one outstanding read at a time.
*/
`timescale 1ns/1ps
module nv_memory_model #(
   parameter logic [95:0] IMG = 96'h0
) (
   input wire logic clk,
   input wire logic nvReadReq,
   input wire logic [3:0] nvAddr,
   output logic nvReadValid,
   output logic [7:0] nvReadData,
   input wire logic seFetchReq,
   output logic seFetchDone,
   output logic [4:0] served
);
   // Answers reads after a random wait; data churns when idle
   initial begin
      logic [3:0] a;
      nvReadValid = 1'b0;
      seFetchDone = 1'b0;
      nvReadData = 8'h00;
      served = 5'h00;
      forever begin
         @(posedge clk);
         #1;
         nvReadValid = 1'b0;
         seFetchDone = 1'b0;
         nvReadData = ~nvReadData;
         if (nvReadReq) begin
            a = nvAddr;
            repeat ($urandom_range(3)) @(posedge clk);
            #1;
            nvReadValid = 1'b1;
            nvReadData = IMG[{a, 3'b000} +: 8];
            served = served + 5'h01;
         end else if (seFetchReq) begin
            repeat (2) @(posedge clk);
            #1;
            seFetchDone = 1'b1;
         end
      end
   end
endmodule // nv_memory_model

// *** bench/tb_top.sv ***
/*
 Testbench for the configuration loader and DAC limiter.
 Assumes the memory model and the bound port checker.
*/
`timescale 1ns/1ps
module tb_top;
   // Word c lower limit, word 6+c upper; channel 5 inverted
   localparam logic [95:0] IMG = 96'h50307FFF80F0_90207F004010;
   logic clk, rst_b, supplyPresent, lockoutReleased, seFetchDone, busStart;
   logic nvReadReq, nvReadValid, seFetchReq, busAckAllow, loadComplete;
   logic driverWeakPull, driverHighZ;
   logic [3:0] nvAddr;
   logic [7:0] nvReadData;
   logic [4:0] served;
   logic [47:0] dacCodeRegister, dacCode;
   logic [5:0] dacBufferEnable;
   logic [53:0] expQ[$];
   int errTotal, checksDone;
   config_download_dac_limiter uut (.clk, .rst_b, .supplyPresent, .lockoutReleased,
      .nvReadReq, .nvAddr, .nvReadValid, .nvReadData, .seFetchReq, .seFetchDone, .busStart,
      .busAckAllow, .loadComplete, .driverWeakPull, .driverHighZ, .dacCodeRegister, .dacCode,
      .dacBufferEnable);
   nv_memory_model #(.IMG(IMG)) nvm (.clk, .nvReadReq, .nvAddr, .nvReadValid, .nvReadData,
      .seFetchReq, .seFetchDone, .served);
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      checksDone++;
      if (seen !== exp) begin
         errTotal++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic results;
      $display("checks %0d, mismatches %0d", checksDone, errTotal);
      if (errTotal == 0 && checksDone > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic bus;
      busStart = 1'b1;
      @(posedge clk);
      #1 busStart = 1'b0;
   endtask
   // Clipped code of channel w
   function automatic logic [7:0] clip(input logic [7:0] c, input int w);
      if (c < IMG[8*w +: 8]) return IMG[8*w +: 8];
      if (c > IMG[48+8*w +: 8]) return IMG[48+8*w +: 8];
      return c;
   endfunction
   // Result watcher: oldest note against the limiter outputs
   initial begin
      logic [53:0] e;
      forever begin
         @(posedge clk);
         if (expQ.size() > 0) begin
            repeat (2) @(posedge clk);
            #2;
            e = expQ.pop_front();
            check(dacCode[39:0], e[45:6]);
            check(dacBufferEnable, e[5:0]);
         end
      end
   end
   // Power up, load, bus refusal, clipping, first state fetch
   initial begin
      int n;
      logic [47:0] c, e;
      rst_b = 1'b0;
      supplyPresent = 1'b0;
      lockoutReleased = 1'b0;
      busStart = 1'b0;
      dacCodeRegister = 48'h0;
      n = $urandom(48);
      repeat (2) @(posedge clk);
      #1 rst_b = 1'b1;
      check(driverHighZ, 1);
      supplyPresent = 1'b1;
      repeat (5) @(posedge clk);
      #1 check({driverWeakPull, driverHighZ, nvReadReq}, 3'b100);
      bus();
      check(busAckAllow, 0);
      $display("power test done");
      lockoutReleased = 1'b1;
      n = 0;
      while (loadComplete !== 1'b1 && n < 400) begin
         if (n == 20) bus();
         check(busAckAllow, 0);
         @(posedge clk);
         #1 n++;
      end
      if (n == 400) begin
         errTotal++;
         results();
      end
      check(served, 12);
      @(posedge clk);
      #1 check(busAckAllow, 0);
      bus();
      repeat (2) @(posedge clk);
      #1 check({busAckAllow, seFetchReq}, 2'b10);
      $display("load test done");
      for (int k = 0; k < 40; k++) begin
         c = 48'({$urandom(), $urandom()});
         if (k == 0) c = IMG[47:0];
         if (k == 1) c = IMG[95:48];
         if (k == 2) c = IMG[47:0] - 48'h010101010101;
         if (k == 3) c = IMG[95:48] + 48'h010101010101;
         for (int w = 0; w < 6; w++) e[8*w +: 8] = clip(c[8*w +: 8], w);
         dacCodeRegister = c;
         expQ.push_back({e, 6'h1F});
         repeat (3) @(posedge clk);
         #1;
      end
      repeat (4) @(posedge clk);
      $display("clip test done");
      n = 0;
      while (seFetchReq !== 1'b1 && n < 21000) begin
         @(posedge clk);
         #1 n++;
      end
      if (n == 21000) begin
         errTotal++;
         results();
      end
      repeat (6) @(posedge clk);
      #1 check(seFetchReq, 0);
      $display("sequencer test done");
      results();
   end
endmodule // tb_top
bind config_download_dac_limiter config_loader_properties chk (.clk, .rst_b, .supplyPresent,
   .lockoutReleased, .nvReadReq, .nvAddr, .nvReadValid, .seFetchReq, .seFetchDone, .busStart,
   .busAckAllow, .loadComplete, .driverWeakPull);
